//--- twc_pkg.sv
// shared constants, register map and carrier types for the timer waveform block
// assumes a classic wishbone master with 32-bit data and byte addresses
package twc_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;

  // register byte addresses
  localparam logic [7:0] ADR_CTRL_A = 8'h24;
  localparam logic [7:0] ADR_CTRL_B = 8'h28;
  localparam logic [7:0] ADR_COUNT  = 8'h2C;
  localparam logic [7:0] ADR_CMP_A  = 8'h30;
  localparam logic [7:0] ADR_CMP_B  = 8'h34;
  localparam logic [7:0] ADR_FLAGS  = 8'h38;
  localparam logic [7:0] ADR_PINDIR = 8'h3C;

  // control_a fields
  localparam int unsigned A_ACT_HI = 7;
  localparam int unsigned A_ACT_LO = 6;
  localparam int unsigned B_ACT_HI = 5;
  localparam int unsigned B_ACT_LO = 4;
  localparam logic [7:0]  CTRL_A_WMASK = 8'hF3;
  // control_b fields
  localparam int unsigned MODE_HI_BIT = 3;
  localparam logic [7:0]  CTRL_B_WMASK = 8'h0F;
  localparam logic [7:0]  RESET_VAL = 8'h00;

  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // compare action codes
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // prescale terminal counts (divisor minus one) by clock select code
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_64   = 10'h03F;
  localparam logic [9:0] DIV_256  = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    CLS_NORMAL,
    CLS_CTC,
    CLS_FAST,
    CLS_PHASE
  } twc_cls_e;

  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } twc_wb_req_s;

  typedef struct packed {
    logic       tick;
    twc_cls_e   cls;
    logic [1:0] act;
    logic       mode_hi;
    logic       match;
    logic       bottom;
    logic       top;
    logic       up;
    logic       special;
  } twc_unit_ctl_s;

endpackage : twc_pkg

//--- twc_out_unit.sv
// one compare output: decides set, clear or toggle of its level per timer tick
// assumes the caller hands in raw events from the shared counter along with the tick that qualifies them here
`timescale 1ns/10ps
module twc_out_unit
  import twc_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b1
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // events and settings
  input  wire twc_pkg::twc_unit_ctl_s ctl,
  // output level
  output logic                    level
);
  import twc_pkg::*;

  logic level_reg;
  logic level_next;
  logic idle_lvl;
  logic toggle_ok;

  assign idle_lvl  = ~ctl.act[0];
  // channel b has no toggle in pwm modes
  assign toggle_ok = IS_CHAN_A && ctl.mode_hi;

  always_comb begin
    level_next = level_reg;
    if (ctl.tick) begin
      case (ctl.cls)
        CLS_NORMAL, CLS_CTC: begin
          if (ctl.match) begin
            case (ctl.act)
              ACT_TOGGLE: level_next = ~level_reg;
              ACT_CLEAR:  level_next = 1'b0;
              ACT_SET:    level_next = 1'b1;
              default:    level_next = level_reg;
            endcase
          end
        end
        CLS_FAST: begin
          if (ctl.act == ACT_TOGGLE) begin
            if (ctl.match && toggle_ok) level_next = ~level_reg;
          end else if (ctl.act[1]) begin
            if (ctl.special) begin
              // chan a settles at bottom, chan b at top
              if (IS_CHAN_A ? ctl.bottom : ctl.top) level_next = idle_lvl;
            end else if (ctl.match) begin
              level_next = ctl.act[0];
            end else if (ctl.bottom) begin
              level_next = idle_lvl;
            end
          end
        end
        CLS_PHASE: begin
          if (ctl.act == ACT_TOGGLE) begin
            if (ctl.match && toggle_ok) level_next = ~level_reg;
          end else if (ctl.act[1]) begin
            if (ctl.special) begin
              if (ctl.top) level_next = idle_lvl;
            end else if (ctl.match) begin
              level_next = ctl.up ? ctl.act[0] : idle_lvl;
            end
          end
        end
        default: level_next = level_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) level_reg <= 1'b0;
    else        level_reg <= level_next;
  end

  assign level = level_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_NONPWM_SET: assert property (
    ctl.tick && ctl.match && (ctl.cls == CLS_NORMAL) && (ctl.act == ACT_SET) |=> level_reg)
    else $error("set on match did not drive level high");

  AST_FAST_CLEAR: assert property (
    ctl.tick && ctl.match && !ctl.special && (ctl.cls == CLS_FAST) && (ctl.act == ACT_CLEAR)
    |=> !level_reg)
    else $error("fast pwm clear on match failed");

  AST_PHASE_DOWN: assert property (
    ctl.tick && ctl.match && !ctl.special && !ctl.up && (ctl.cls == CLS_PHASE)
    && (ctl.act == ACT_CLEAR) |=> level_reg)
    else $error("phase pwm down match did not set level");

endmodule : twc_out_unit

//--- twc_wave_ctrl.sv
// timer waveform control: counter, mode decode, compare buffers and two outputs
// assumes a classic wishbone master; pins resolved outside from out/oe pairs
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
module twc_wave_ctrl
  import twc_pkg::*;
(
  // clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                RST_N,
  // wishbone slave
  input  wire twc_pkg::twc_wb_req_s WB_REQ,
  output logic [31:0]              WB_DAT_O,
  output logic                     WB_ACK_O,
  // compare output pins
  output logic                     CMP_A_OUT,
  output logic                     CMP_A_OE,
  output logic                     CMP_B_OUT,
  output logic                     CMP_B_OE
);
  import twc_pkg::*;

  function automatic logic [9:0] div_of(input logic [2:0] cs);
    case (cs)
      3'h2:    div_of = DIV_8;
      3'h3:    div_of = DIV_64;
      3'h4:    div_of = DIV_256;
      3'h5:    div_of = DIV_1024;
      default: div_of = '0;
    endcase
  endfunction : div_of

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  ctrl_a_reg, ctrl_a_next;
  logic [7:0]  ctrl_b_reg, ctrl_b_next;
  logic [7:0]  cmp_a_buf_reg, cmp_a_buf_next;
  logic [7:0]  cmp_b_buf_reg, cmp_b_buf_next;
  logic [7:0]  cmp_a_reg, cmp_a_next;
  logic [7:0]  cmp_b_reg, cmp_b_next;
  logic [1:0]  pindir_reg, pindir_next;
  logic        ovf_reg, ovf_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [7:0]  count_reg, count_next;
  logic        up_reg, up_next;
  logic        block_reg, block_next;
  logic [9:0]  pre_reg, pre_next;
  logic        oa_reg, oa_next, oea_reg, oea_next;
  logic        ob_reg, ob_next, oeb_reg, oeb_next;

  logic        wr, rd_req, tick;
  logic [2:0]  mode;
  twc_cls_e    cls;
  logic [7:0]  top_val;
  logic        at_top, at_bottom, ovf_set;
  logic        lvl_a, lvl_b;
  twc_unit_ctl_s ctl_a, ctl_b;

  assign wr     = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && !ack_reg && WB_REQ.sel[0];
  assign rd_req = WB_REQ.cyc && WB_REQ.stb && !ack_reg;
  assign mode   = {ctrl_b_reg[MODE_HI_BIT], ctrl_a_reg[1:0]};

  always_comb begin
    case (mode)
      3'h1, 3'h5: cls = CLS_PHASE;
      3'h2:       cls = CLS_CTC;
      3'h3, 3'h7: cls = CLS_FAST;
      default:    cls = CLS_NORMAL; // reserved codes count as normal
    endcase
  end

  assign top_val   = (mode == 3'h2 || mode == 3'h5 || mode == 3'h7) ? cmp_a_reg : CNT_MAX;
  assign at_top    = (count_reg == top_val);
  assign at_bottom = (count_reg == CNT_BOTTOM);

  // prescaler: one-cycle tick per timer clock; external clock codes stop it
  always_comb begin
    pre_next = '0;
    tick     = 1'b0;
    if (ctrl_b_reg[2:0] == 3'h1) begin
      tick = 1'b1;
    end else if (div_of(ctrl_b_reg[2:0]) != '0) begin
      tick     = (pre_reg == div_of(ctrl_b_reg[2:0]));
      pre_next = tick ? '0 : pre_reg + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter
  always_comb begin
    count_next = count_reg;
    up_next    = up_reg;
    block_next = block_reg && !tick;
    if (wr && WB_REQ.adr == ADR_COUNT) begin
      count_next = WB_REQ.dat[7:0];
      block_next = 1'b1; // suppress the next tick's match
    end else if (tick) begin
      case (cls)
        CLS_PHASE: begin
          if (up_reg) begin
            if (count_reg >= top_val) begin
              up_next    = 1'b0;
              count_next = at_bottom ? count_reg : count_reg - 8'h01;
            end else begin
              count_next = count_reg + 8'h01;
            end
          end else if (at_bottom) begin
            up_next    = 1'b1;
            count_next = (top_val == CNT_BOTTOM) ? count_reg : count_reg + 8'h01;
          end else begin
            count_next = count_reg - 8'h01;
          end
        end
        CLS_CTC, CLS_FAST: count_next = at_top ? CNT_BOTTOM : count_reg + 8'h01;
        default:           count_next = count_reg + 8'h01;
      endcase
    end
    if (cls != CLS_PHASE) up_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and compare buffers
  always_comb begin
    ovf_set = 1'b0;
    if (tick) begin
      case (mode)
        3'h0, 3'h2, 3'h3: ovf_set = (count_reg == CNT_MAX);
        3'h1, 3'h5:       ovf_set = at_bottom && !up_reg;
        3'h7:             ovf_set = at_top;
        default:          ovf_set = 1'b0;
      endcase
    end
  end

  always_comb begin
    ctrl_a_next    = ctrl_a_reg;
    ctrl_b_next    = ctrl_b_reg;
    cmp_a_buf_next = cmp_a_buf_reg;
    cmp_b_buf_next = cmp_b_buf_reg;
    pindir_next    = pindir_reg;
    ovf_next       = ovf_reg;
    if (wr) begin
      case (WB_REQ.adr)
        ADR_CTRL_A: ctrl_a_next    = WB_REQ.dat[7:0] & CTRL_A_WMASK;
        ADR_CTRL_B: ctrl_b_next    = WB_REQ.dat[7:0] & CTRL_B_WMASK;
        ADR_CMP_A:  cmp_a_buf_next = WB_REQ.dat[7:0];
        ADR_CMP_B:  cmp_b_buf_next = WB_REQ.dat[7:0];
        ADR_PINDIR: pindir_next    = WB_REQ.dat[1:0];
        ADR_FLAGS:  ovf_next       = ovf_reg && !WB_REQ.dat[0];
        default:    ctrl_a_next    = ctrl_a_reg;
      endcase
    end
    if (ovf_set) ovf_next = 1'b1; // set beats clear
    // active compares follow the buffer per mode
    cmp_a_next = cmp_a_reg;
    cmp_b_next = cmp_b_reg;
    if (cls == CLS_NORMAL || cls == CLS_CTC ||
        (tick && at_top && (cls == CLS_PHASE || cls == CLS_FAST))) begin
      cmp_a_next = cmp_a_buf_reg;
      cmp_b_next = cmp_b_buf_reg;
    end
  end

  // bus answer: ack one cycle after the request, unmapped reads zero
  always_comb begin
    ack_next  = WB_REQ.cyc && WB_REQ.stb && !ack_reg;
    rdat_next = '0;
    if (rd_req) begin
      case (WB_REQ.adr)
        ADR_CTRL_A: rdat_next[7:0] = ctrl_a_reg & CTRL_A_WMASK;
        ADR_CTRL_B: rdat_next[7:0] = ctrl_b_reg;
        ADR_COUNT:  rdat_next[7:0] = count_reg;
        ADR_CMP_A:  rdat_next[7:0] = cmp_a_buf_reg;
        ADR_CMP_B:  rdat_next[7:0] = cmp_b_buf_reg;
        ADR_FLAGS:  rdat_next[0]   = ovf_reg;
        ADR_PINDIR: rdat_next[1:0] = pindir_reg;
        default:    rdat_next      = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output units
  always_comb begin
    ctl_a.tick    = tick;
    ctl_a.cls     = cls;
    ctl_a.act     = ctrl_a_reg[A_ACT_HI:A_ACT_LO];
    ctl_a.mode_hi = mode[2];
    ctl_a.match   = (count_reg == cmp_a_reg) && !block_reg;
    // fast pwm reaches bottom on the wrap tick that leaves top, so the duty is compare plus one
    ctl_a.bottom  = (cls == CLS_FAST) ? at_top : at_bottom;
    ctl_a.top     = at_top;
    ctl_a.up      = up_reg;
    ctl_a.special = (cmp_a_reg == top_val);
    ctl_b         = ctl_a;
    ctl_b.act     = ctrl_a_reg[B_ACT_HI:B_ACT_LO];
    ctl_b.match   = (count_reg == cmp_b_reg) && !block_reg;
    ctl_b.special = (cmp_b_reg == top_val);
  end

  twc_out_unit #(.IS_CHAN_A(1'b1)) u_unit_a (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ctl   (ctl_a),
    .level (lvl_a)
  );

  twc_out_unit #(.IS_CHAN_A(1'b0)) u_unit_b (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ctl   (ctl_b),
    .level (lvl_b)
  );

  // pin drive only when an action is chosen and the direction says output
  always_comb begin
    oa_next  = lvl_a;
    oea_next = (ctrl_a_reg[A_ACT_HI:A_ACT_LO] != ACT_OFF) && pindir_reg[0];
    // toggle code in pwm without the high mode bit leaves the pin to the port
    if (ctrl_a_reg[A_ACT_HI:A_ACT_LO] == ACT_TOGGLE && !mode[2] && (cls == CLS_FAST || cls == CLS_PHASE)) begin
      oea_next = 1'b0;
    end
    ob_next  = lvl_b;
    oeb_next = (ctrl_a_reg[B_ACT_HI:B_ACT_LO] != ACT_OFF) && pindir_reg[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_a_reg    <= RESET_VAL;
      ctrl_b_reg    <= RESET_VAL;
      cmp_a_buf_reg <= RESET_VAL;
      cmp_b_buf_reg <= RESET_VAL;
      cmp_a_reg     <= RESET_VAL;
      cmp_b_reg     <= RESET_VAL;
      count_reg     <= RESET_VAL;
      pindir_reg    <= '0;
      ovf_reg       <= 1'b0;
      ack_reg       <= 1'b0;
      rdat_reg      <= '0;
      up_reg        <= 1'b1;
      block_reg     <= 1'b0;
      pre_reg       <= '0;
      oa_reg        <= 1'b0;
      oea_reg       <= 1'b0;
      ob_reg        <= 1'b0;
      oeb_reg       <= 1'b0;
    end else begin
      ctrl_a_reg    <= ctrl_a_next;
      ctrl_b_reg    <= ctrl_b_next;
      cmp_a_buf_reg <= cmp_a_buf_next;
      cmp_b_buf_reg <= cmp_b_buf_next;
      cmp_a_reg     <= cmp_a_next;
      cmp_b_reg     <= cmp_b_next;
      count_reg     <= count_next;
      pindir_reg    <= pindir_next;
      ovf_reg       <= ovf_next;
      ack_reg       <= ack_next;
      rdat_reg      <= rdat_next;
      up_reg        <= up_next;
      block_reg     <= block_next;
      pre_reg       <= pre_next;
      oa_reg        <= oa_next;
      oea_reg       <= oea_next;
      ob_reg        <= ob_next;
      oeb_reg       <= oeb_next;
    end
  end

  assign WB_DAT_O  = rdat_reg;
  assign WB_ACK_O  = ack_reg;
  assign CMP_A_OUT = oa_reg;
  assign CMP_A_OE  = oea_reg;
  assign CMP_B_OUT = ob_reg;
  assign CMP_B_OE  = oeb_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  AST_A_OE_GATE: assert property (
    CMP_A_OE |-> $past(ctrl_a_reg[A_ACT_HI:A_ACT_LO] != ACT_OFF) && $past(pindir_reg[0]))
    else $error("pin a enabled without action or direction");

  AST_B_OE_GATE: assert property (
    ##1 ($past(ctrl_a_reg[B_ACT_HI:B_ACT_LO] != ACT_OFF) && $past(pindir_reg[1])) == CMP_B_OE)
    else $error("pin b enable does not follow action and direction");

  AST_RSVD_ZERO: assert property (
    WB_ACK_O && $past(WB_REQ.adr == ADR_CTRL_A) |-> WB_DAT_O[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");

  AST_FAST_CLS: assert property (
    (mode == 3'h3 || mode == 3'h7) |-> cls == CLS_FAST)
    else $error("fast pwm mode decoded wrong");

  AST_TOP_SRC: assert property (
    (mode == 3'h1) |-> top_val == CNT_MAX)
    else $error("top not max in mode 1");

  AST_IMM_UPDATE: assert property (
    (cls == CLS_NORMAL) && $stable(cls) [*2] |-> cmp_a_reg == $past(cmp_a_buf_reg))
    else $error("compare not immediate in normal mode");

  AST_OVF_MAX: assert property (
    tick && (mode == 3'h0) && (count_reg == CNT_MAX) |=> ovf_reg)
    else $error("overflow flag missed at max");

  AST_PHASE_TURN: assert property (
    tick && (cls == CLS_PHASE) && up_reg && at_top && !at_bottom && !wr
    |=> !up_reg && count_reg == $past(count_reg) - 8'h01)
    else $error("phase counter did not turn at top");

  AST_ACK_ONE: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack stood more than one cycle");

  COV_FAST: cover property (tick && cls == CLS_FAST && at_top);
  COV_PHASE: cover property (tick && cls == CLS_PHASE && at_bottom && !up_reg);
  COV_OVF: cover property (ovf_set);
  COV_PIN_A: cover property (CMP_A_OE ##1 $changed(CMP_A_OUT));

endmodule : twc_wave_ctrl

//--- twc_pin_model.sv
// external pin fed by one compare output and its drive enable
// assumes out and oe come straight from the block, registered on the system clock
`timescale 1ns/10ps
module twc_pin_model (
  // clock
  input  wire logic clk,
  // from the block
  input  wire logic drv,
  input  wire logic oe,
  // resolved pin level
  output logic      pin
);
  logic last_reg = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (oe) begin
      last_reg <= drv;
    end
  end

  // no pull on this pin: once released it shows the inverse of the last level
  assign pin = oe ? drv : ~last_reg;
endmodule : twc_pin_model

//--- tb.sv
// self-checking bench: registers over classic wishbone, pin duty per mode and action
// assumes twc_pkg, the design and twc_pin_model are compiled before this file
`timescale 1ns/10ps
module tb;
  import twc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  twc_wb_req_s req = '0;
  logic [31:0] dat_o;
  logic        ack;
  logic        a_out, a_oe, b_out, b_oe, pin_a, pin_b;
  int          failures = 0;
  int          comparisons = 0;
  logic [31:0] rd;
  logic [15:0] ha, hb;
  logic [7:0]  ca, cb;
  logic [7:0]  adrs [8] = '{ADR_CTRL_A, ADR_CTRL_B, ADR_COUNT, ADR_CMP_A, ADR_CMP_B, ADR_FLAGS, ADR_PINDIR, 8'h40};

  always #20 clk = ~clk;

  twc_wave_ctrl dut (.SYS_CLK(clk), .RST_N(rst_n), .WB_REQ(req), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
                     .CMP_A_OUT(a_out), .CMP_A_OE(a_oe), .CMP_B_OUT(b_out), .CMP_B_OE(b_oe));
  twc_pin_model u_pin_a (.clk(clk), .drv(a_out), .oe(a_oe), .pin(pin_a));
  twc_pin_model u_pin_b (.clk(clk), .drv(b_out), .oe(b_oe), .pin(pin_b));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t high count got %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt

  // entered just after a rising edge; leaves cyc low for one cycle
  task automatic wb(input logic [7:0] adr, input logic we, input logic [7:0] wd);
    int n;
    n = 0;
    req <= '{adr: adr, dat: {24'h0, wd}, sel: 4'hF, we: we, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_o;
    req <= '0;
    @(posedge clk);
    if (n >= 16) begin
      failures++;
      close_out();
    end
  endtask : wb

  // high ticks over two periods; the window makes the pipeline delay irrelevant
  function automatic logic [15:0] exp_hi(input logic [2:0] mm, input logic [1:0] act,
                                         input logic [7:0] c, input logic [7:0] tp, input logic [15:0] w);
    logic [15:0] h;
    if (act == 2'h1) return w >> 1;
    if (mm == 3'h0 || mm == 3'h2) return (act == 2'h3) ? w : 16'h0;
    if (c >= tp) h = w;
    else if (mm[1]) h = {7'h0, c, 1'b0} + 16'h2;
    else h = {6'h0, c, 2'h0};
    return (act == 2'h3) ? w - h : h;
  endfunction : exp_hi

  task automatic run(input logic [2:0] mm, input logic [1:0] xa, input logic [1:0] xb,
                     input logic [7:0] va, input logic [7:0] vb, input logic [1:0] dir);
    logic [7:0]  tp;
    logic [15:0] w;
    logic        oea;
    logic        oeb;
    wb(ADR_CMP_A, 1'b1, va);
    wb(ADR_CMP_B, 1'b1, vb);
    wb(ADR_CTRL_B, 1'b1, {4'h0, mm[2], 3'h1});
    wb(ADR_CTRL_A, 1'b1, {xa, xb, 2'h0, mm[1:0]});
    wb(ADR_PINDIR, 1'b1, {6'h0, dir});
    tp = (mm == 3'h2 || mm[2]) ? va : 8'hFF;
    w = (mm[1:0] == 2'h1) ? {6'h0, tp, 2'h0} : {7'h0, tp, 1'b0} + 16'h2;
    oea = (xa != 2'h0) && dir[0] && !(xa == 2'h1 && mm[0] && !mm[2]);
    oeb = (xb != 2'h0) && dir[1];
    repeat (1100) @(posedge clk);
    chk_reg({30'h0, a_oe, b_oe}, {30'h0, oea, oeb});
    ha = '0;
    hb = '0;
    repeat (w) begin
      @(posedge clk);
      ha += {15'h0, pin_a === 1'b1};
      hb += {15'h0, pin_b === 1'b1};
    end
    if (oea) chk_cnt(ha, exp_hi(mm, xa, va, tp, w));
    if (oeb && !(xb == 2'h1 && mm[0])) chk_cnt(hb, exp_hi(mm, xb, vb, tp, w));
  endtask : run

  // timer stopped, count preset, flag cleared, then run and read the flag
  task automatic ovf(input logic [2:0] mm, input logic [7:0] cnt, input int cyc, input logic e);
    wb(ADR_CTRL_B, 1'b1, {4'h0, mm[2], 3'h0});
    wb(ADR_CTRL_A, 1'b1, {6'h0, mm[1:0]});
    wb(ADR_COUNT, 1'b1, cnt);
    wb(ADR_FLAGS, 1'b1, 8'h01);
    wb(ADR_CTRL_B, 1'b1, {4'h0, mm[2], 3'h1});
    repeat (cyc) @(posedge clk);
    wb(ADR_FLAGS, 1'b0, 8'h00);
    chk_reg(rd, {31'h0, e});
  endtask : ovf

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(37253));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (adrs[i]) begin
      wb(adrs[i], 1'b0, 8'h00);
      chk_reg(rd, 32'h0);
    end
    wb(ADR_CTRL_A, 1'b1, 8'hFF);
    wb(ADR_CTRL_A, 1'b0, 8'h00);
    chk_reg(rd, 32'hF3);
    wb(ADR_CTRL_B, 1'b1, 8'hFF);
    wb(ADR_CTRL_B, 1'b0, 8'h00);
    chk_reg(rd, {24'h0, CTRL_B_WMASK});
    wb(8'h40, 1'b1, 8'hFF);
    wb(8'h40, 1'b0, 8'h00);
    chk_reg(rd, 32'h0);
    wb(ADR_CTRL_A, 1'b1, 8'h00);
    wb(ADR_CMP_A, 1'b1, 8'h40);
    ovf(3'h0, 8'hF0, 40, 1'b1);
    ovf(3'h2, 8'h10, 100, 1'b0);
    ovf(3'h1, 8'hF0, 100, 1'b0);
    ovf(3'h1, 8'hF0, 400, 1'b1);
    ovf(3'h7, 8'h10, 60, 1'b1);
    for (int k = 0; k < 2; k++) begin
      ca = 8'($urandom_range(250, 8));
      cb = 8'($urandom_range(ca - 1, 1));
      run(3'h3, 2'h2, 2'h3, ca, cb, 2'h3);
      run(3'h1, 2'h2, 2'h3, ca, cb, 2'h3);
      run(3'h7, 2'h1, 2'h2, ca, cb, 2'h3);
      run(3'h5, 2'h2, 2'h2, ca, cb, 2'h3);
      run(3'h2, 2'h1, 2'h1, ca, cb, 2'h3);
    end
    run(3'h3, 2'h3, 2'h2, 8'hFF, 8'hFF, 2'h3);
    run(3'h1, 2'h3, 2'h2, 8'hFF, 8'hFF, 2'h3);
    run(3'h7, 2'h2, 2'h3, ca, ca, 2'h3);
    run(3'h0, 2'h3, 2'h2, ca, cb, 2'h3);
    run(3'h0, 2'h1, 2'h0, ca, cb, 2'h1);
    run(3'h3, 2'h1, 2'h1, ca, cb, 2'h3);
    run(3'h2, 2'h3, 2'h3, ca, cb, 2'h2);
    close_out();
  end
endmodule : tb
